/* canopen_pdo_regs.vh */
// Register offsets, field positions, reset values and timing constants
// Notes on behaviour
// - Async type 255 sends on events and on event timer expiry
// - Resend within event time; default 1000 ms
// - Inhibit time blocks resend; default 100 ms
// - Ten receive and ten transmit PDOs
// - PDO payload at most eight bytes
// - Received payloads packed into input image
// - Transmit payloads read packed from output image
// - Size counts words; bytes are twice
// - Master receive PDO1 COB-ID: slave plus 180h
// - Master transmit PDO1 COB-ID: slave plus 200h
// - Dynamic option uses host station number
// - Heartbeat produced every cycle time
// - Partner heartbeat checked against guard time
// - Parameter zone disabled when value zero
// - Selectable bit rate including 125 kbit/s
`ifndef CANOPEN_PDO_REGS_VH
`define CANOPEN_PDO_REGS_VH
`define A_OIMG 8'h00
`define A_IIMG 8'h40
`define IMG_WORDS 40
`define A_CTRL 8'h80
`define A_NODE 8'h81
`define A_PCNT 8'h82
`define A_PZONE 8'h83
`define A_STAT 8'h84
`define A_MASK 8'h85
`define A_STATE 8'h86
`define A_TRIG 8'h87
`define A_INH 8'h88
`define A_EVT 8'h89
`define A_HBC 8'h8a
`define A_GUARD 8'h8b
`define A_RCFG 8'h90
`define A_TCFG 8'ha0
`define CTRL_EN 0
`define CTRL_MASTER 1
`define CTRL_DYN 2
`define CTRL_BAUD_LSB 4
`define BAUD_1M 3'h0
`define BAUD_125K 3'h3
`define CTRL_RST 16'h0031
`define NODE_RST 16'h0201
`define PCNT_RST 16'h0a0a
`define CFG_ROLE 11
`define CFG_SZ_LSB 12
`define CFG_RST 16'h4800
`define INH_MS 16'h0064
`define EVT_MS 16'h03e8
`define HBC_MS 16'h03e8
`define GUARD_MS 16'h041a
`define ST_HBLOST 0
`define ST_RX 1
`define ST_TX 2
`define COB_RX_M 11'h180
`define COB_RX_S 11'h200
`define COB_HB 11'h700
`define HB_STATE 8'h05
`define MS_NS 1000000
`define CLK_NS 5
`define MS_CYCLES (`MS_NS / `CLK_NS)
`endif

/* canopen_pdo_heartbeat_engine.v */
// PDO scheduling, image mapping and heartbeat engine for a CANopen node
`include "canopen_pdo_regs.vh"
module canopen_pdo_heartbeat_engine #(
  parameter NPDO      = 10,          // PDOs per direction
  parameter MS_CYCLES = `MS_CYCLES   // Clock cycles per millisecond tick
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Host context
  input  wire [6:0]  station_no,
  input  wire [9:0]  tpdo_event,
  // Frame receive from CAN controller
  input  wire        rx_valid,
  input  wire [10:0] rx_cob,
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] rx_data,
  // Frame transmit to CAN controller
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg  [10:0] tx_cob,
  output reg  [3:0]  tx_dlc,
  output reg  [63:0] tx_data,
  // Controller settings and status
  output wire [2:0]  baud_sel,
  output wire        pzone_en,
  output wire        irq
);

  // Configuration registers
  reg [15:0] ctrl_r;                 // Enable, role, dynamic id, baud
  reg [15:0] node_r;                 // Own id low, slave id high
  reg [15:0] pcnt_r;                 // Active rx/tx PDO counts
  reg [15:0] pzone_r;                // Parameter zone size
  reg [2:0]  stat_r;                 // Sticky events
  reg [2:0]  mask_r;                 // Interrupt mask
  reg [15:0] inh_r;                  // Inhibit time, ms
  reg [15:0] evt_r;                  // Event time, ms
  reg [15:0] hbc_r;                  // Heartbeat cycle, ms
  reg [15:0] guard_r;                // Guard time, ms
  reg [15:0] rcfg_r [0:NPDO-1];      // Receive PDO config
  reg [15:0] tcfg_r [0:NPDO-1];      // Transmit PDO config
  reg [15:0] oimg_r [0:`IMG_WORDS-1]; // Output image, host written
  reg [15:0] iimg_r [0:`IMG_WORDS-1]; // Input image, device written
  // Scheduler state
  reg [NPDO-1:0] pend_r;             // Transmission wanted
  reg [16:0]     inh_cnt_r [0:NPDO-1]; // Inhibit ticks left
  reg [15:0]     ev_cnt_r [0:NPDO-1];  // Ticks since last send
  reg [31:0]     pre_r;              // Millisecond prescaler
  reg            tick_r;             // One-cycle ms tick
  reg [15:0]     hb_cnt_r;           // Heartbeat producer timer
  reg            hb_pend_r;          // Heartbeat frame wanted
  reg [15:0]     gd_cnt_r;           // Guard timer
  reg            lost_r;             // Partner heartbeat missing
  integer        i;
  integer        w;
  integer        p, ri, mi, ti, gw;  // One loop index per process, none shared
  wire       en     = ctrl_r[`CTRL_EN];
  wire       master = ctrl_r[`CTRL_MASTER];
  wire [6:0] slave  = node_r[14:8];
  // Own node id from host station when dynamic
  wire [6:0] own = ctrl_r[`CTRL_DYN] ? station_no : node_r[6:0];
  assign baud_sel = ctrl_r[`CTRL_BAUD_LSB+2:`CTRL_BAUD_LSB];
  assign pzone_en = (pzone_r != 16'h0000);
  assign irq      = |(stat_r & mask_r);

  // Size in words, clamped to four words of eight bytes
  function [2:0] sz_of;
    input [15:0] cfg;
    begin
      sz_of = (cfg[14:12] > 3'h4) ? 3'h4 : cfg[14:12];
    end
  endfunction

  // Count of active PDOs, clamped to ten
  function [3:0] cnt_of;
    input [3:0] c;
    begin
      cnt_of = (c > 4'ha) ? 4'ha : c;
    end
  endfunction

  // Image word where PDO idx starts: sum of earlier sizes
  function [5:0] base_of;
    input [29:0] sz;
    input [3:0]  idx;
    input [3:0]  n;
    integer k;
    begin
      base_of = 6'h00;
      for (k = 0; k < 10; k = k + 1)
        if (k < idx && k < n)
          base_of = base_of + {3'h0, sz[3*k +: 3]};
    end
  endfunction

  // COB-ID by role for PDO 1..4, else the stored value
  function [10:0] cob_of;
    input [15:0] cfg;
    input        rx;
    input [3:0]  idx;
    input        mst;
    input [6:0]  own_id;
    input [6:0]  slv_id;
    reg   [10:0] b;
    begin
      b = (rx ^ mst) ? `COB_RX_S : `COB_RX_M;
      if (cfg[`CFG_ROLE] && idx < 4'h4)
        cob_of = b + {1'b0, idx[1:0], 8'h00} + {4'h0, mst ? slv_id : own_id};
      else
        cob_of = cfg[10:0];
    end
  endfunction

  // Packed size vectors for the base functions
  reg [29:0] rsz;
  reg [29:0] tsz;
  always @*
  begin
    rsz = 30'h0;
    tsz = 30'h0;
    for (ri = 0; ri < NPDO; ri = ri + 1)
    begin
      rsz[3*ri +: 3] = sz_of(rcfg_r[ri]);
      tsz[3*ri +: 3] = sz_of(tcfg_r[ri]);
    end
  end
  // Receive PDO match, lowest index wins
  reg       rx_hit;
  reg [3:0] rx_idx;
  always @*
  begin
    rx_hit = 1'b0;
    rx_idx = 4'h0;
    for (mi = NPDO - 1; mi >= 0; mi = mi - 1)
      if (mi < cnt_of(pcnt_r[3:0]) &&
          rx_cob == cob_of(rcfg_r[mi], 1'b1, mi[3:0], master, own, slave))
      begin
        rx_hit = 1'b1;
        rx_idx = mi[3:0];
      end
  end
  wire       rx_pdo = en && rx_valid && rx_hit;
  wire [5:0] rx_base = base_of(rsz, rx_idx, cnt_of(pcnt_r[3:0]));
  wire       rx_hb = en && rx_valid && rx_cob == (`COB_HB + {4'h0, slave});
  wire       lost_set = en && !lost_r && guard_r != 16'h0 && gd_cnt_r >= guard_r; // Guard expired
  // Transmit pick: ready PDO of lowest index
  reg       tp_hit;
  reg [3:0] tp_idx;
  always @*
  begin
    tp_hit = 1'b0;
    tp_idx = 4'h0;
    for (ti = NPDO - 1; ti >= 0; ti = ti - 1)
      if (pend_r[ti] && inh_cnt_r[ti] == 17'h0 && ti < cnt_of(pcnt_r[11:8]))
      begin
        tp_hit = 1'b1;
        tp_idx = ti[3:0];
      end
  end
  wire       tx_free = !tx_valid || tx_ready;
  wire       hb_go   = en && tx_free && hb_pend_r;
  wire       tp_go   = en && tx_free && !hb_pend_r && tp_hit;
  wire [5:0] tp_base = base_of(tsz, tp_idx, cnt_of(pcnt_r[11:8]));
  wire [2:0] tp_sz   = sz_of(tcfg_r[tp_idx]);
  // Payload gathered from the output image
  reg [63:0] tp_data;
  always @*
  begin
    tp_data = 64'h0;
    for (gw = 0; gw < 4; gw = gw + 1)
      if (gw < tp_sz && tp_base + gw < `IMG_WORDS)
        tp_data[16*gw +: 16] = oimg_r[tp_base + gw];
  end
  // Millisecond tick; count is long so it is a parameter
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_r  <= 32'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      // Wrap and tick in the same cycle
      tick_r <= (pre_r >= MS_CYCLES - 1);
      pre_r  <= (pre_r >= MS_CYCLES - 1) ? 32'h0 : pre_r + 32'h1;
    end
  end

  // Register writes and input image updates
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r  <= `CTRL_RST;
      node_r  <= `NODE_RST;
      pcnt_r  <= `PCNT_RST;
      pzone_r <= 16'h0000;
      mask_r  <= 3'h0;
      inh_r   <= `INH_MS;
      evt_r   <= `EVT_MS;
      hbc_r   <= `HBC_MS;
      guard_r <= `GUARD_MS;
      for (i = 0; i < NPDO; i = i + 1)
      begin
        rcfg_r[i] <= `CFG_RST;
        tcfg_r[i] <= `CFG_RST;
      end
      for (i = 0; i < `IMG_WORDS; i = i + 1)
      begin
        oimg_r[i] <= 16'h0000;
        iimg_r[i] <= 16'h0000;
      end
    end
    else
    begin
      // Host side writes
      if (reg_wr)
      begin
        if (reg_addr < `A_OIMG + `IMG_WORDS)
          oimg_r[reg_addr[5:0]] <= reg_wdata;
        else if (reg_addr >= `A_RCFG && reg_addr < `A_RCFG + NPDO)
          rcfg_r[reg_addr[3:0]] <= reg_wdata;
        else if (reg_addr >= `A_TCFG && reg_addr < `A_TCFG + NPDO)
          tcfg_r[reg_addr[3:0]] <= reg_wdata;
        else
          case (reg_addr)
            `A_CTRL:  ctrl_r  <= reg_wdata;
            `A_NODE:  node_r  <= reg_wdata;
            `A_PCNT:  pcnt_r  <= {4'h0, cnt_of(reg_wdata[11:8]), 4'h0, cnt_of(reg_wdata[3:0])};
            `A_PZONE: pzone_r <= reg_wdata;
            `A_MASK:  mask_r  <= reg_wdata[2:0];
            `A_INH:   inh_r   <= reg_wdata;
            `A_EVT:   evt_r   <= reg_wdata;
            `A_HBC:   hbc_r   <= reg_wdata;
            `A_GUARD: guard_r <= reg_wdata;
            default:  ;
          endcase
      end
      // Received payload, low byte first per word
      if (rx_pdo)
        for (w = 0; w < 4; w = w + 1)
          if (w < sz_of(rcfg_r[rx_idx]) && rx_base + w < `IMG_WORDS)
            iimg_r[rx_base + w] <= rx_data[16*w +: 16];
    end
  end

  // Sticky status; a new event beats a same-cycle clear
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stat_r <= 3'h0;
    else
    begin
      if (reg_wr && reg_addr == `A_STAT)
        stat_r <= (stat_r & ~reg_wdata[2:0]) |
                  {tx_valid && tx_ready, rx_pdo, lost_set};
      else
        stat_r <= stat_r | {tx_valid && tx_ready, rx_pdo, lost_set};
    end
  end
  // Per-PDO event, event-timer and inhibit handling
  wire [9:0] trig = (reg_wr && reg_addr == `A_TRIG) ? reg_wdata[9:0] : 10'h0;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_r <= {NPDO{1'b0}};
      for (p = 0; p < NPDO; p = p + 1)
      begin
        inh_cnt_r[p] <= 17'h0;
        ev_cnt_r[p]  <= 16'h0;
      end
    end
    else
      for (p = 0; p < NPDO; p = p + 1)
        if (tp_go && tp_idx == p)
        begin
          // Sent now; restart both timers, keep a coincident event
          pend_r[p]    <= tpdo_event[p] | trig[p];
          inh_cnt_r[p] <= {1'b0, inh_r} + 17'h1;
          ev_cnt_r[p]  <= 16'h0;
        end
        else
        begin
          // Only events or the event timer ask for a send
          if (tpdo_event[p] || trig[p] ||
              (evt_r != 16'h0 && ev_cnt_r[p] >= evt_r))
            pend_r[p] <= en;
          if (tick_r && inh_cnt_r[p] != 17'h0)
            inh_cnt_r[p] <= inh_cnt_r[p] - 17'h1;
          if (tick_r && ev_cnt_r[p] != 16'hffff)
            ev_cnt_r[p] <= ev_cnt_r[p] + 16'h1;
        end
  end
  // Heartbeat producer and partner guard
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      hb_cnt_r  <= 16'h0;
      hb_pend_r <= 1'b0;
      gd_cnt_r  <= 16'h0;
      lost_r    <= 1'b0;
    end
    else
    begin
      // Produce at the cycle time; zero switches it off
      if (hb_go)
        hb_pend_r <= 1'b0;
      else if (en && hbc_r != 16'h0 && hb_cnt_r >= hbc_r)
        hb_pend_r <= 1'b1;
      if (!en || (hbc_r != 16'h0 && hb_cnt_r >= hbc_r))
        hb_cnt_r <= 16'h0;
      else if (tick_r)
        hb_cnt_r <= hb_cnt_r + 16'h1;
      // Any partner heartbeat rearms the guard
      if (!en || rx_hb)
      begin
        gd_cnt_r <= 16'h0;
        lost_r   <= 1'b0;
      end
      else
      begin
        if (tick_r && !lost_r)
          gd_cnt_r <= gd_cnt_r + 16'h1;
        if (lost_set)
          lost_r <= 1'b1;
      end
    end
  end
  // Frame output; held until the controller accepts it
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_valid <= 1'b0;
      tx_cob   <= 11'h0;
      tx_dlc   <= 4'h0;
      tx_data  <= 64'h0;
    end
    else if (hb_go)
    begin
      tx_valid <= 1'b1;
      tx_cob   <= `COB_HB + {4'h0, own};
      tx_dlc   <= 4'h1;
      tx_data  <= {56'h0, `HB_STATE};
    end
    else if (tp_go)
    begin
      tx_valid <= 1'b1;
      tx_cob   <= cob_of(tcfg_r[tp_idx], 1'b0, tp_idx, master, own, slave);
      tx_dlc   <= {tp_sz, 1'b0};
      tx_data  <= tp_data;
    end
    else if (tx_ready)
      tx_valid <= 1'b0;
  end
  // Read data, one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0;
    else if (!reg_rd)
      reg_rdata <= 16'h0;
    else if (reg_addr < `A_OIMG + `IMG_WORDS)
      reg_rdata <= oimg_r[reg_addr[5:0]];
    else if (reg_addr >= `A_IIMG && reg_addr < `A_IIMG + `IMG_WORDS)
      reg_rdata <= iimg_r[reg_addr[5:0] - 6'h00];
    else if (reg_addr >= `A_RCFG && reg_addr < `A_RCFG + NPDO)
      reg_rdata <= rcfg_r[reg_addr[3:0]];
    else if (reg_addr >= `A_TCFG && reg_addr < `A_TCFG + NPDO)
      reg_rdata <= tcfg_r[reg_addr[3:0]];
    else
      case (reg_addr)
        `A_CTRL:  reg_rdata <= ctrl_r;
        `A_NODE:  reg_rdata <= node_r;
        `A_PCNT:  reg_rdata <= pcnt_r;
        `A_PZONE: reg_rdata <= pzone_r;
        `A_STAT:  reg_rdata <= {13'h0, stat_r};
        `A_MASK:  reg_rdata <= {13'h0, mask_r};
        `A_STATE: reg_rdata <= {tx_valid, lost_r, hb_pend_r, 6'h0, own};
        `A_INH:   reg_rdata <= inh_r;
        `A_EVT:   reg_rdata <= evt_r;
        `A_HBC:   reg_rdata <= hbc_r;
        `A_GUARD: reg_rdata <= guard_r;
        default:  reg_rdata <= 16'h0;
      endcase
  end

endmodule

/* pdo_engine_assertions.sv */
// Port-level checker for the PDO and heartbeat engine
`include "canopen_pdo_regs.vh"
module pdo_engine_checker #(
  parameter MS_CYCLES = `MS_CYCLES  // Cycles per ms tick
) (
  // Clock and reset
  input logic        mclk,
  input logic        rstn,
  // Register port
  input logic [7:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  // Frame transmit
  input logic        tx_valid,
  input logic        tx_ready,
  input logic [10:0] tx_cob,
  input logic [3:0]  tx_dlc,
  input logic [63:0] tx_data,
  // Settings
  input logic [2:0]  baud_sel,
  input logic        pzone_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INH = `INH_MS * MS_CYCLES;  // Default inhibit in cycles
  logic [31:0] gap_r;   // Cycles since last PDO acceptance, wide for the real tick
  logic        seen_r;  // A PDO was accepted before
  wire pdo_acc = tx_valid && tx_ready && tx_cob[10:8] == 3'h2;
  // Saturating gap counter; only COB-IDs 200h to 2FFh are timed
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      gap_r  <= 32'h0000_0000;
      seen_r <= 1'b0;
    end
    else if (pdo_acc)
    begin
      gap_r  <= 32'h0000_0000;
      seen_r <= 1'b1;
    end
    else if (gap_r != 32'hffff_ffff)
      gap_r <= gap_r + 32'h0000_0001;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable({tx_cob, tx_dlc, tx_data});
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame dropped or changed");
  property p_dlc_max;
    tx_valid |-> tx_dlc <= 4'h8;
  endproperty
  a_dlc_max: assert property (p_dlc_max) else $error("payload too long");
  property p_dlc_even;
    tx_valid && tx_cob[10:7] != 4'he |-> !tx_dlc[0];
  endproperty
  a_dlc_even: assert property (p_dlc_even) else $error("odd PDO length");
  property p_hb_frame;
    tx_valid && tx_cob[10:7] == 4'he |-> tx_dlc == 4'h1 && tx_data[7:0] == `HB_STATE;
  endproperty
  a_hb_frame: assert property (p_hb_frame) else $error("bad heartbeat frame");
  property p_pzone;
    reg_wr && reg_addr == `A_PZONE |=> pzone_en == (|$past(reg_wdata));
  endproperty
  a_pzone: assert property (p_pzone) else $error("zone enable wrong");
  property p_baud;
    reg_wr && reg_addr == `A_CTRL |=> baud_sel == $past(reg_wdata[6:4]);
  endproperty
  a_baud: assert property (p_baud) else $error("bit rate select wrong");
  property p_inhibit;
    pdo_acc && seen_r |-> gap_r >= INH;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("PDO inside inhibit");
endmodule
bind canopen_pdo_heartbeat_engine pdo_engine_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_cob(tx_cob), .tx_dlc(tx_dlc), .tx_data(tx_data), .baud_sel(baud_sel), .pzone_en(pzone_en));

/* can_ctrl_model.sv */
// Behavioural CAN controller on the engine's frame ports
module can_ctrl_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Transmit side
  input  wire logic        tx_valid,
  input  wire logic [10:0] tx_cob,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [63:0] tx_data,
  output logic             tx_ready,
  // Receive side
  output logic             rx_valid,
  output logic [10:0]      rx_cob,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  // Acceptance delay per frame
  input  wire logic [3:0]  stall
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cyc;      // Cycle count
  int unsigned fr_cnt;   // Frames accepted
  int unsigned fr_time;  // Cycle of last acceptance
  logic [10:0] fr_cob;   // Last frame fields
  logic [3:0]  fr_dlc;
  logic [63:0] fr_data;
  logic [3:0]  wait_r;   // Cycles current frame waited
  initial
  begin
    rx_valid = 1'b0;
    rx_cob   = 11'h000;
    rx_dlc   = 4'h0;
    rx_data  = 64'h0;
  end
  // Ready is dropped after each acceptance, so every frame sees the stall
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      tx_ready <= 1'b0;
      wait_r   <= 4'h0;
      cyc      <= 0;
      fr_cnt   <= 0;
    end
    else
    begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready)
      begin
        fr_cnt   <= fr_cnt + 1;
        fr_time  <= cyc;
        fr_cob   <= tx_cob;
        fr_dlc   <= tx_dlc;
        fr_data  <= tx_data;
        tx_ready <= 1'b0;
        wait_r   <= 4'h0;
      end
      else if (tx_valid)
      begin
        wait_r   <= wait_r + 4'h1;
        tx_ready <= (wait_r >= stall);
      end
    end
  // One received frame; lines show inverted junk afterwards
  task automatic send_rx(input logic [10:0] cob, input logic [63:0] data);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_cob   <= cob;
    rx_dlc   <= 4'h8;
    rx_data  <= data;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_cob   <= ~cob;
    rx_dlc   <= 4'h7;
    rx_data  <= ~data;
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the PDO and heartbeat engine
`include "canopen_pdo_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid, pzone_en, irq;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [6:0] station_no;
  logic [9:0] tpdo_event;
  logic [10:0] rx_cob, tx_cob;
  logic [3:0] rx_dlc, tx_dlc, stall;
  logic [63:0] rx_data, tx_data;
  logic [2:0] baud_sel;
  int num_errors, num_checks, t0, n;
  canopen_pdo_heartbeat_engine #(.MS_CYCLES(10)) i_dut (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .station_no(station_no), .tpdo_event(tpdo_event),
    .rx_valid(rx_valid), .rx_cob(rx_cob), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_cob(tx_cob), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .baud_sel(baud_sel), .pzone_en(pzone_en), .irq(irq));
  can_ctrl_model i_can (.mclk(mclk), .rstn(rstn), .tx_valid(tx_valid), .tx_cob(tx_cob),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_cob(rx_cob), .rx_dlc(rx_dlc), .rx_data(rx_data), .stall(stall));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  // Bounded wait for the model's frame count
  task automatic wait_frame(input int cnt, input int bound);
    int i = 0;
    while (i_can.fr_cnt < cnt && i < bound)
    begin
      @(posedge mclk);
      #1 i++;
    end
    chk(i_can.fr_cnt >= cnt, 1);
    if (i_can.fr_cnt < cnt)
      end_sim();
  endtask
  task automatic pulse_evt;
    @(posedge mclk);
    tpdo_event <= 10'h001;
    @(posedge mclk);
    tpdo_event <= 10'h000;
  endtask
  initial
  begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, tpdo_event} = '0;
    station_no = 7'h15;
    stall = 4'h0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd_chk(`A_CTRL, 16'h0031, 16'hffff);
    rd_chk(`A_NODE, 16'h0201, 16'hffff);
    rd_chk(`A_TCFG, 16'h4800, 16'hffff);
    wr(`A_PCNT, 16'h0f0f);
    rd_chk(`A_PCNT, 16'h0a0a, 16'hffff);
    rd_chk(8'h7f, 16'h0000, 16'hffff);
    chk(baud_sel, 3);
    $display("test reset done");
    wr(`A_CTRL, 16'h0002);
    #1 chk(baud_sel, 0);
    wr(`A_PCNT, 16'h0101);
    wr(`A_HBC, 16'h0000);
    wr(`A_GUARD, 16'h0000);
    wr(`A_TCFG, 16'h3800);
    wr(`A_RCFG, 16'h3800);
    for (int k = 0; k < 3; k++)
      wr(`A_OIMG + k, 16'ha000 + k);
    wr(`A_CTRL, 16'h0033);
    pulse_evt();
    wait_frame(1, 20);
    chk(i_can.fr_cob, 11'h202);
    chk(i_can.fr_dlc, 6);
    chk(i_can.fr_data[47:0], 48'ha002_a001_a000);
    t0 = i_can.fr_time;
    pulse_evt();
    wait_frame(2, 2000);
    chk_rng(i_can.fr_time - t0, 1000, 1030);
    t0 = i_can.fr_time;
    wait_frame(3, 11000);
    chk_rng(i_can.fr_time - t0, 9990, 10030);
    $display("test transmit done");
    wr(`A_STAT, 16'h0007);
    i_can.send_rx(11'h185, 64'h1);
    wr(`A_IIMG, 16'hdead);
    rd_chk(`A_IIMG, 16'h0000, 16'hffff);
    i_can.send_rx(11'h182, 64'h7777_6666_5555_4444);
    for (int k = 0; k < 4; k++)
      rd_chk(`A_IIMG + k, k < 3 ? 16'h4444 + 16'h1111 * k : 16'h0000, 16'hffff);
    rd_chk(`A_STAT, 16'h0002, 16'h0002);
    $display("test receive done");
    stall <= 4'h3;
    wr(`A_CTRL, 16'h0037);
    wr(`A_HBC, 16'h0005);
    n = i_can.fr_cnt;
    wait_frame(n + 1, 200);
    t0 = i_can.fr_time;
    chk(i_can.fr_cob, 11'h715);
    rd_chk(`A_STATE, 16'h0015, 16'h007f);
    wait_frame(n + 2, 200);
    t0 = i_can.fr_time;
    wait_frame(n + 3, 200);
    chk_rng(i_can.fr_time - t0, 45, 60);
    wr(`A_HBC, 16'h0000);
    $display("test heartbeat done");
    wr(`A_MASK, 16'h0001);
    wr(`A_GUARD, 16'h0014);
    i_can.send_rx(11'h702, 64'h5);
    wr(`A_STAT, 16'h0007);
    #1 n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk_rng(n, 180, 225);
    if (n >= 400)
      end_sim();
    rd_chk(`A_STAT, 16'h0001, 16'h0001);
    i_can.send_rx(11'h702, 64'h5);
    wr(`A_STAT, 16'h0001);
    #1 chk(irq, 0);
    wr(`A_MASK, 16'h0000);
    $display("test guard done");
    wr(`A_PZONE, 16'h0000);
    #1 chk(pzone_en, 0);
    wr(`A_PZONE, 16'h0005);
    #1 chk(pzone_en, 1);
    $display("test zone done");
    end_sim();
  end
endmodule
